// file: swdr_pkg.sv
// shared constants and carriers for the switch diagnostic readback block
// assumes a 16-bit serial frame and two channel banks
package swdr_pkg;

  localparam int NUM_CH = 2;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // register select codes, low three address bits; ADDR_RESET covers the full 4-bit address
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_FAULT = 3'h1;
  localparam logic [2:0] ADDR_PWM = 3'h2;
  localparam logic [2:0] ADDR_CONF = 3'h3;
  localparam logic [2:0] ADDR_OCR = 3'h4;
  localparam logic [2:0] ADDR_RETRY = 3'h5;
  localparam logic [2:0] ADDR_GCR = 3'h6;
  localparam logic [2:0] ADDR_DIAG = 3'h7;
  localparam logic [3:0] ADDR_RESET = 4'h0;

  // incoming frame layout
  localparam int SI_WD_BIT = 15;
  localparam int SI_BANK_BIT = 13;
  localparam logic [2:0] SI_SELECT_TAG = 3'h0;

  // outgoing frame layout
  localparam int SO_WD_BIT = 15;
  localparam int SO_PERR_BIT = 14;
  localparam int SO_ECHO_LSB = 10;
  localparam int SO_NM_BIT = 9;

  // fault register fields
  localparam int FLT_OC_BIT = 0;
  localparam int FLT_SC_BIT = 1;
  localparam int FLT_OS_BIT = 3;
  localparam int FLT_OLOFF_BIT = 4;
  localparam int FLT_OLON_BIT = 5;
  localparam int FLT_OTW_BIT = 8;
  // flag vector order inside a channel: olon, oloff, os, sc, oc
  localparam logic [4:0] LATCHED_MASK = 5'h03;

  // open-load-on thresholds per sense ratio, milliamps
  localparam int OLON_THR_HIGH_MA = 150;
  localparam int OLON_THR_LOW_MA = 7;

  // diagnostic fields; the product code value is arbitrary
  localparam logic [1:0] PRODUCT_CODE = 2'h2;
  localparam int DIAG_LOAD_TYPE_PIN_CH1_BIT = 8;
  localparam int DIAG_LOAD_TYPE_PIN_CH0_BIT = 7;
  localparam int DIAG_ID_LSB = 5;
  localparam int DIAG_IN1_BIT = 4;
  localparam int DIAG_IN0_BIT = 3;
  localparam int DIAG_CLKERR_BIT = 2;

  localparam int NUM_SYNC = 7;

  typedef struct packed {
    logic below_high_thr;
    logic below_low_thr;
    logic open_load_off;
    logic output_to_supply;
    logic severe_short;
    logic overcurrent;
  } swdr_cause_t;

  typedef struct packed {
    logic [8:0] pwm;
    logic [8:0] conf;
    logic [8:0] ocr;
    logic offset_positive;
    logic [3:0] retry_count;
    logic [3:0] retry_cfg;
  } swdr_chan_rb_t;

endpackage

// file: swdr_fault_chan.sv
// one channel's fault flags with latching and clear-on-read
// assumes read_clr_i and delatch_i are one-cycle pulses on clk_sys_i
`timescale 1ns/1ns
module swdr_fault_chan
  import swdr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [4:0] cause_i,
  input wire logic delatch_i,
  input wire logic read_clr_i,
  output logic [4:0] flags_o
);

  logic [4:0] latch_q;
  logic [4:0] latch_d;
  logic [4:0] flag_q;
  logic [4:0] flag_d;
  logic [4:0] cause_held;

  // latched causes survive until delatch; a new cause still wins
  assign latch_d = (latch_q & ~{5{delatch_i}}) | (cause_i & LATCHED_MASK);
  assign cause_held = cause_i | latch_q;
  // read clears only causes that are gone; set beats clear
  assign flag_d = (flag_q & ~({5{read_clr_i}} & ~cause_held)) | cause_i;
  assign flags_o = flag_q;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      latch_q <= 5'h00;
      flag_q <= 5'h00;
    end else if (ce_i) begin
      latch_q <= latch_d;
      flag_q <= flag_d;
    end
  end

  // a newly latched cause may join; only the old latched bits must stay
  latch_hold_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && !delatch_i && (latch_q[0] || latch_q[1]) |=>
      (flag_q & $past(latch_q) & LATCHED_MASK) ==
      ($past(latch_q) & LATCHED_MASK))
    else $error("latched fault dropped without delatch");

  unread_keep_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && !read_clr_i |=> (flag_q & $past(flag_q)) == $past(flag_q))
    else $error("fault flag lost without a read");

  read_clear_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && read_clr_i && cause_i == 5'h00 && latch_q == 5'h00 |=>
      flag_q == 5'h00)
    else $error("fault register not cleared by read");

endmodule

// file: swdr_readback.sv
// serial readback of the switch fault, retry, config and diagnostic registers
// assumes the serial pins and strap pins are asynchronous to clk_sys_i;
// register contents and fault causes come from core logic on clk_sys_i
`timescale 1ns/1ns
//
// Contract
// - prewarning sets both fault registers, outputs untouched
// - reading either fault register clears both prewarnings
// - fault register bank follows previous address bank bit
// - bit0 overcurrent, bit1 severe short circuit
// - bit3 supply short, bit4 open off, bit5 open on
// - open-on threshold follows selected sense ratio
// - fault status pin low on any channel fault
// - latched faults clear only by delatching
// - read clears faults whose cause has gone
// - pwm, conf, overcurrent readback from addressed bank
// - retry readback: offset bit8, counter bits7..4
// - zero counter means no retry or disabled
// - global configuration readback ignores bank bit
// - diag bits 8,7 show load-type pins
// - diag bits 6,5 hold fixed product code
// - diag bits 4,3 show live direct inputs
// - diag bit2 flags external clock error
// - diag bits 1,0 flag calibration failure
// - address one frame, data out next frame
// - frame top: watchdog, parity error, address echo
// - frame bit9 shows normal mode
module swdr_readback
  import swdr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic csb_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_n_o,
  output logic fault_status_n_o,
  input wire logic overtemp_prewarning_i,
  input wire swdr_cause_t [NUM_CH-1:0] fault_cause_i,
  input wire logic [NUM_CH-1:0] delatch_i,
  input wire logic [NUM_CH-1:0] sense_ratio_low_i,
  input wire swdr_chan_rb_t [NUM_CH-1:0] chan_rb_i,
  input wire logic [8:0] gcr_rb_i,
  input wire logic [8:0] status_rb_i,
  input wire logic load_type_pin_ch0_i,
  input wire logic load_type_pin_ch1_i,
  input wire logic [NUM_CH-1:0] direct_in_i,
  input wire logic ext_clk_sel_i,
  input wire logic ext_clk_err_i,
  input wire logic [NUM_CH-1:0] cal_fail_i,
  input wire logic normal_mode_i
);

  // pin synchronisers; stage one feeds only stage two
  logic [NUM_SYNC-1:0] sync1_q;
  logic [NUM_SYNC-1:0] sync2_q;
  wire [NUM_SYNC-1:0] pins_raw = {sclk_i, csb_n_i, si_i, load_type_pin_ch0_i,
                                  load_type_pin_ch1_i, direct_in_i};

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sync1_q <= 7'h30;
      sync2_q <= 7'h30;
    end else if (ce_i) begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire sclk_s = sync2_q[6];
  wire csb_s = sync2_q[5];
  wire si_s = sync2_q[4];
  wire load_type_pin_ch0_s = sync2_q[3];
  wire load_type_pin_ch1_s = sync2_q[2];
  wire [1:0] din_s = sync2_q[1:0];

  // frame state
  logic sclk_prev_q;
  logic csb_prev_q;
  logic [15:0] shift_out_q;
  logic [15:0] shift_in_q;
  logic [4:0] bit_cnt_q;
  logic [3:0] soa_q;
  logic [3:0] out_sel_q;
  logic wd_prev_q;
  logic perr_q;
  logic so_q;
  logic so_oe_n_q;
  logic [NUM_CH-1:0] read_clr_q;
  logic otw_q;
  logic fsn_q;

  wire active = !csb_s;
  wire csb_fall = csb_prev_q && !csb_s;
  wire csb_rise = !csb_prev_q && csb_s;
  wire sclk_rise = active && !sclk_prev_q && sclk_s;
  wire sclk_fall = active && sclk_prev_q && !sclk_s;
  // a short or long frame is invalid and leaves the address alone
  wire frame_ok = csb_rise && (bit_cnt_q == FRAME_BITS);
  wire parity_good = ^shift_in_q; // odd parity over the whole word
  wire select_frame = shift_in_q[12:10] == SI_SELECT_TAG;
  wire take_addr = frame_ok && parity_good && select_frame;
  wire [3:0] new_addr = {shift_in_q[SI_BANK_BIT], shift_in_q[2:0]};
  wire fault_read = frame_ok && (out_sel_q[2:0] == ADDR_FAULT);
  wire [NUM_CH-1:0] read_clr_d = {NUM_CH{fault_read}} &
                                 {out_sel_q[3], !out_sel_q[3]};

  // fault flags per channel
  logic [4:0] cause_vec [NUM_CH];
  logic [4:0] flags [NUM_CH];
  logic [8:0] fault_word [NUM_CH];
  logic [8:0] retry_word [NUM_CH];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      // open-on threshold picked by sense ratio; comparators sit outside
      wire olon = sense_ratio_low_i[ch] ? fault_cause_i[ch].below_low_thr
                                        : fault_cause_i[ch].below_high_thr;
      assign cause_vec[ch] = {olon, fault_cause_i[ch].open_load_off,
                              fault_cause_i[ch].output_to_supply,
                              fault_cause_i[ch].severe_short,
                              fault_cause_i[ch].overcurrent};

      swdr_fault_chan u_fault (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .cause_i(cause_vec[ch]),
        .delatch_i(delatch_i[ch]),
        .read_clr_i(read_clr_q[ch]),
        .flags_o(flags[ch])
      );

      assign fault_word[ch] = {otw_q, 2'h0, flags[ch][4:2], 1'b0,
                               flags[ch][1:0]};
      // counter passes straight through; zero means none or disabled
      assign retry_word[ch] = {chan_rb_i[ch].offset_positive,
                               chan_rb_i[ch].retry_count,
                               chan_rb_i[ch].retry_cfg};
    end
  endgenerate

  // prewarning is common: one flag shows in both banks, never gates outputs
  wire otw_d = overtemp_prewarning_i || (otw_q && !(|read_clr_q));
  wire any_fault = (|flags[0]) || (|flags[1]);

  wire [8:0] diag_word = {load_type_pin_ch1_s, load_type_pin_ch0_s, PRODUCT_CODE, din_s[1], din_s[0],
                          ext_clk_sel_i && ext_clk_err_i, cal_fail_i};

  // register select for the next frame
  wire bank = soa_q[3];
  logic [8:0] reg_data;
  always_comb begin
    case (soa_q[2:0])
      ADDR_STATUS: reg_data = status_rb_i;
      ADDR_FAULT: reg_data = fault_word[bank];
      ADDR_PWM: reg_data = chan_rb_i[bank].pwm;
      ADDR_CONF: reg_data = chan_rb_i[bank].conf;
      ADDR_OCR: reg_data = chan_rb_i[bank].ocr;
      ADDR_RETRY: reg_data = retry_word[bank];
      ADDR_GCR: reg_data = gcr_rb_i;
      ADDR_DIAG: reg_data = diag_word;
      default: reg_data = 9'h000;
    endcase
  end

  wire [15:0] out_word = {wd_prev_q, perr_q, soa_q, normal_mode_i,
                          reg_data};

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sclk_prev_q <= 1'b0;
      csb_prev_q <= 1'b1;
    end else if (ce_i) begin
      sclk_prev_q <= sclk_s;
      csb_prev_q <= csb_s;
    end
  end

  // shift out on sclk rise, sample on sclk fall
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      shift_out_q <= 16'h0000;
      out_sel_q <= ADDR_RESET;
      so_q <= 1'b0;
    end else if (ce_i) begin
      if (csb_fall) begin
        shift_out_q <= out_word;
        out_sel_q <= soa_q;
      end else if (sclk_rise) begin
        so_q <= shift_out_q[15];
        shift_out_q <= {shift_out_q[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      shift_in_q <= 16'h0000;
      bit_cnt_q <= 5'h00;
    end else if (ce_i) begin
      if (csb_fall) begin
        bit_cnt_q <= 5'h00;
      end else if (sclk_fall) begin
        shift_in_q <= {shift_in_q[14:0], si_s};
        if (bit_cnt_q <= FRAME_BITS) begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
      end
    end
  end

  // frame end: commit address and header bits of the next answer
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      soa_q <= ADDR_RESET;
      wd_prev_q <= 1'b0;
      perr_q <= 1'b0;
    end else if (ce_i && frame_ok) begin
      wd_prev_q <= shift_in_q[SI_WD_BIT];
      perr_q <= !parity_good;
      if (take_addr) begin
        soa_q <= new_addr;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      read_clr_q <= 2'h0;
      otw_q <= 1'b0;
      fsn_q <= 1'b1;
      so_oe_n_q <= 1'b1;
    end else if (ce_i) begin
      read_clr_q <= read_clr_d;
      otw_q <= otw_d;
      fsn_q <= !any_fault;
      so_oe_n_q <= !active;
    end
  end

  assign so_o = so_q;
  assign so_oe_n_o = so_oe_n_q;
  assign fault_status_n_o = fsn_q;

  otw_both_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && overtemp_prewarning_i |=>
      fault_word[0][FLT_OTW_BIT] && fault_word[1][FLT_OTW_BIT])
    else $error("prewarning not set in both fault registers");

  otw_clear_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && (|read_clr_q) && !overtemp_prewarning_i |=> !otw_q)
    else $error("prewarning survived a fault read");

  fault_pin_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && any_fault |=> !fault_status_n_o)
    else $error("fault status pin not low on fault");

  frame_load_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && csb_fall |=>
      shift_out_q == $past(out_word) && out_sel_q == $past(soa_q))
    else $error("answer frame not loaded at select");

  oe_follow_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i |=> so_oe_n_o == $past(csb_s))
    else $error("data output enable not following select");

  addr_echo_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && take_addr |=> out_word[13:10] == $past(new_addr))
    else $error("address echo wrong");

  parity_flag_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && frame_ok |=> perr_q == !$past(parity_good))
    else $error("parity error flag wrong");

  bad_frame_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && csb_rise && !frame_ok |=> $stable(soa_q) && $stable(perr_q))
    else $error("invalid frame changed state");

  nm_bit_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && csb_fall && normal_mode_i |=> shift_out_q[SO_NM_BIT])
    else $error("normal mode bit missing");

  fault_clr_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && fault_read |=>
      read_clr_q[$past(out_sel_q[3])] && $onehot(read_clr_q))
    else $error("fault read did not clear addressed bank");

  fault_bank_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && csb_fall && soa_q[2:0] == ADDR_FAULT |=>
      shift_out_q[5:0] == $past(fault_word[bank][5:0]))
    else $error("fault register from wrong bank");

  retry_map_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && csb_fall && soa_q[2:0] == ADDR_RETRY |=>
      shift_out_q[8:4] == $past({chan_rb_i[bank].offset_positive,
                                 chan_rb_i[bank].retry_count}))
    else $error("retry readback fields wrong");

  gcr_common_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && csb_fall && soa_q[2:0] == ADDR_GCR |=>
      shift_out_q[8:0] == $past(gcr_rb_i))
    else $error("global configuration readback wrong");

  diag_id_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && csb_fall && soa_q[2:0] == ADDR_DIAG |=>
      shift_out_q[DIAG_ID_LSB+1:DIAG_ID_LSB] == PRODUCT_CODE)
    else $error("product code wrong");

  diag_din_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && csb_fall && soa_q[2:0] == ADDR_DIAG |=>
      shift_out_q[DIAG_IN1_BIT:DIAG_IN0_BIT] == $past(din_s))
    else $error("direct input state wrong");

  cov_fault_read_c: cover property (
    @(posedge clk_sys_i) fault_read && any_fault);
  cov_parity_err_c: cover property (
    @(posedge clk_sys_i) frame_ok && !parity_good);
  cov_diag_c: cover property (
    @(posedge clk_sys_i) take_addr && new_addr[2:0] == ADDR_DIAG);
  cov_bank1_c: cover property (
    @(posedge clk_sys_i) csb_fall && soa_q == 4'h9);
  // low ratio open-on seen in bank 1
  cov_ratio_c: cover property (
    @(posedge clk_sys_i) sense_ratio_low_i[1] && flags[1][4]);

endmodule

// file: swdr_spi_master.sv
// serial master model facing the switch readback block
// assumes clk_sys_i at 25 MHz; sclk period 320 ns, idle low outside frames
`timescale 1ns/1ns
module swdr_spi_master (
  input wire logic clk_sys_i,
  output logic sclk_o,
  output logic csb_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_n_i
);
  initial begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    si_o = 1'b0;
  end

  // one 16-bit frame msb first; odd parity carried in bit 14
  // the word sent selects what the next frame returns
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    logic [15:0] t;
    t = w;
    t[14] = ~^{w[15], w[13:0]};
    @(negedge clk_sys_i);
    csb_n_o = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'b1;
      si_o = t[i];
      repeat (4) @(negedge clk_sys_i);
      sclk_o = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      // sampled late in the low phase; the output path lags by 2-3 clk
      r[i] = so_oe_n_i ? 1'bx : so_i;
    end
    repeat (2) @(negedge clk_sys_i);
    // released data line shows no stale value
    si_o = ~si_o;
    csb_n_o = 1'b1;
    repeat (10) @(negedge clk_sys_i);
  endtask
endmodule

// file: swdr_readback_tb.sv
// self-checking bench for the switch readback block
// assumes the serial master model drives the link pins
`timescale 1ns/1ns
module swdr_readback_tb;
  import swdr_pkg::*;
  logic clk_sys_i, reset_i, sclk, csb_n, si, so, so_oe_n, fsn;
  logic overtemp_prewarning, ext_sel, ext_err, pin0, pin1;
  swdr_cause_t [NUM_CH-1:0] cause;
  swdr_chan_rb_t [NUM_CH-1:0] crb;
  logic [NUM_CH-1:0] delatch, srl, din, cal;
  logic [8:0] gcr, stat;
  logic [3:0] prev_a;
  logic prev_wd;
  logic nm, ce;
  int failures, samples_checked;

  swdr_readback u_swdr_readback (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce),
    .sclk_i(sclk), .csb_n_i(csb_n), .si_i(si), .so_o(so),
    .so_oe_n_o(so_oe_n), .fault_status_n_o(fsn),
    .overtemp_prewarning_i(overtemp_prewarning), .fault_cause_i(cause),
    .delatch_i(delatch), .sense_ratio_low_i(srl), .chan_rb_i(crb),
    .gcr_rb_i(gcr), .status_rb_i(stat), .load_type_pin_ch0_i(pin0),
    .load_type_pin_ch1_i(pin1), .direct_in_i(din),
    .ext_clk_sel_i(ext_sel), .ext_clk_err_i(ext_err),
    .cal_fail_i(cal), .normal_mode_i(nm));

  swdr_spi_master u_swdr_spi_master (
    .clk_sys_i(clk_sys_i), .sclk_o(sclk), .csb_n_o(csb_n), .si_o(si),
    .so_i(so), .so_oe_n_i(so_oe_n));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic report_and_stop();
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // returns the register chosen last frame and selects nxt
  task automatic look(input string what, input logic [3:0] nxt,
                      input logic [8:0] exp);
    logic [15:0] got;
    u_swdr_spi_master.xfer({~prev_wd, 1'b0, nxt[3], 10'h000, nxt[2:0]}, got);
    cmp(what, {prev_wd, 1'b0, prev_a, nm, exp}, got);
    prev_wd = ~prev_wd;
    prev_a = nxt;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  initial begin
    #400000;
    failures++;
    report_and_stop();
  end

  initial begin
    reset_i = 1'b1;
    nm = 1'b1;
    ce = 1'b1;
    overtemp_prewarning = 1'b0;
    cause = '0;
    delatch = 2'h0;
    srl = 2'h2;
    gcr = 9'h1B2;
    stat = 9'h0C5;
    pin0 = 1'b0;
    pin1 = 1'b1;
    din = 2'h1;
    ext_sel = 1'b1;
    ext_err = 1'b1;
    cal = 2'h2;
    crb[0] = '{9'h15A, 9'h0C3, 9'h1F0, 1'b1, 4'h0, 4'h9};
    crb[1] = '{9'h0A5, 9'h13C, 9'h00F, 1'b0, 4'hB, 4'h6};
    prev_a = 4'h0;
    prev_wd = 1'b0;
    failures = 0;
    samples_checked = 0;
    ticks(8);
    reset_i = 1'b0;
    ticks(4);
    cmp("fault pin idle", 16'h0001, {15'h0, fsn});
    // a cause seen only while frozen must leave no flag
    ce = 1'b0;
    cause[1] = 6'h04;
    ticks(4);
    cmp("frozen fault pin", 16'h0001, {15'h0, fsn});
    cause = '0;
    ce = 1'b1;
    ticks(4);
    cmp("thawed fault pin", 16'h0001, {15'h0, fsn});
    look("status", 4'h7, stat);
    look("diag", 4'h7, {2'b10, PRODUCT_CODE, 5'b01110});
    pin0 = 1'b1;
    pin1 = 1'b0;
    din = 2'h2;
    ext_sel = 1'b0;
    cal = 2'h1;
    ticks(4);
    look("diag", 4'h2, {2'b01, PRODUCT_CODE, 5'b10001});
    for (int b = 0; b < 2; b++) begin
      look("pwm", {b[0], ADDR_CONF}, crb[b].pwm);
      look("conf", {b[0], ADDR_OCR}, crb[b].conf);
      look("ocr", {b[0], ADDR_RETRY}, crb[b].ocr);
      look("retry", {b[0], ADDR_GCR}, {crb[b].offset_positive,
           crb[b].retry_count, crb[b].retry_cfg});
      look("gcr", b == 0 ? 4'hA : 4'h9, gcr);
    end
    // ch0 latched pulse, ch1 held live causes on the low ratio
    cause[0] = 6'h13;
    cause[1] = 6'h1C;
    overtemp_prewarning = 1'b1;
    ticks(3);
    cause[0] = 6'h10;
    overtemp_prewarning = 1'b0;
    ticks(3);
    cmp("fault pin set", 16'h0000, {15'h0, fsn});
    look("fault1", 4'h1, 9'h138);
    look("fault0", 4'h1, 9'h003);
    cause = '0;
    delatch = 2'h1;
    ticks(1);
    delatch = 2'h0;
    ticks(3);
    look("fault0", 4'h9, 9'h003);
    look("fault1", 4'h1, 9'h038);
    look("fault0", 4'h9, 9'h000);
    nm = 1'b0;
    look("fault1", 4'h0, 9'h000);
    nm = 1'b1;
    ticks(4);
    cmp("fault pin clear", 16'h0001, {15'h0, fsn});
    report_and_stop();
  end
endmodule
